// file: bench/quad_counter_model.sv
`timescale 1ns/1ns
`default_nettype none
module quad_counter_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] quad_in,
    output logic signed [15:0] count_out
);
    logic [1:0] prev_ff;
    always_ff @(posedge clk_in) begin
        prev_ff <= quad_in;
        if (rst_in) begin
            count_out <= 16'sh0;
        end else if (quad_in == {~prev_ff[0], prev_ff[1]}) begin
            count_out <= count_out + 16'sh1;
        end else if (quad_in == {prev_ff[0], ~prev_ff[1]}) begin
            count_out <= count_out - 16'sh1;
        end
    end
endmodule : quad_counter_model
`default_nettype wire

// file: bench/quad_enc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module quad_enc_monitor #(parameter int POS_WIDTH = 16) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic step_in,
    input wire logic dir_up_in,
    input wire logic ref_mark_in,
    input wire logic supply_ok_in,
    input wire logic light_ok_in,
    input wire logic signal_ok_in,
    input wire logic quad_phase_first_out,
    input wire logic quad_phase_second_out,
    input wire logic index_out,
    input wire logic fault_out,
    input wire logic fault_n_out,
    input wire logic [POS_WIDTH-1:0] position_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    wire logic [1:0] q = {quad_phase_first_out, quad_phase_second_out};
    wire logic go = step_in && !fault_out;
    a_fault_pair: assert property (fault_n_out == !fault_out) else $error("fault lines not inverse");
    a_up_order: assert property (go && dir_up_in |=> q == {~$past(q[0]), $past(q[1])})
        else $error("bad up phase");
    a_down_order: assert property (go && !dir_up_in |=> q == {$past(q[0]), ~$past(q[1])})
        else $error("bad down phase");
    a_idle_hold: assert property (!go |=> $stable({q, position_out})) else $error("moved without step");
    a_pos_up: assert property (go && dir_up_in |=> position_out == $past(position_out) + 1'b1)
        else $error("position not up");
    a_pos_down: assert property (go && !dir_up_in |=> position_out == $past(position_out) - 1'b1)
        else $error("position not down");
    a_index_gate: assert property (index_out |-> q == 2'h3) else $error("index outside gate");
    a_index_mark: assert property ($rose(index_out) |-> $past(ref_mark_in)) else $error("index off mark");
    a_fault_health: assert property (!(supply_ok_in && light_ok_in && signal_ok_in) |-> ##[1:6] fault_out)
        else $error("fault not raised");
    cover property (go && dir_up_in);
    cover property (go && !dir_up_in);
    cover property ($rose(index_out));
    cover property ($rose(fault_out));
endmodule : quad_enc_monitor
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic step_in = 1'b0;
    logic dir_up_in = 1'b1;
    logic ref_mark_in = 1'b0;
    logic supply_ok_in = 1'b1;
    logic light_ok_in = 1'b1;
    logic signal_ok_in = 1'b1;
    logic quad_phase_first_out, quad_phase_second_out, index_out, fault_out, fault_n_out;
    logic [15:0] position_out;
    logic signed [15:0] count;
    int num_errors = 0;
    int num_checks = 0;
    always #20 ref_clk_in = ~ref_clk_in;
    quadrature_encoder_output #(.INTERP_FACTOR(10), .POS_WIDTH(16)) uut (.ref_clk_in, .srst_in, .step_in,
        .dir_up_in, .ref_mark_in, .supply_ok_in, .light_ok_in, .signal_ok_in, .quad_phase_first_out,
        .quad_phase_second_out, .index_out, .fault_out, .fault_n_out, .position_out);
    quad_counter_model far (.clk_in(ref_clk_in), .rst_in(srst_in),
        .quad_in({quad_phase_first_out, quad_phase_second_out}), .count_out(count));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic steps(input logic up, input int n);
        repeat (n) begin
            @(posedge ref_clk_in);
            step_in <= 1'b1;
            dir_up_in <= up;
        end
        @(posedge ref_clk_in);
        step_in <= 1'b0;
        repeat (2) @(negedge ref_clk_in);
    endtask : steps
    task automatic wait_fault(input logic exp);
        for (int i = 0; i < 20 && fault_out !== exp; i++) @(negedge ref_clk_in);
        chk(16'(fault_out), 16'(exp));
        chk(16'(fault_n_out), 16'(!exp));
        if (fault_out !== exp) report_and_stop();
    endtask : wait_fault
    task automatic t_reset;
        chk(16'({quad_phase_first_out, quad_phase_second_out, index_out, fault_out, fault_n_out}), 16'h2);
        wait_fault(1'b0);
    endtask : t_reset
    task automatic t_period;
        // One grating period is 4 * INTERP_FACTOR quarter steps, sent back to back
        steps(1'b1, 40);
        chk(16'({quad_phase_first_out, quad_phase_second_out}), 16'h0);
        chk(position_out, 16'h28);
        chk(count, 16'h28);
    endtask : t_period
    task automatic t_index;
        @(posedge ref_clk_in);
        ref_mark_in <= 1'b1;
        for (int k = 1; k <= 4; k++) begin
            steps(1'b1, 1);
            chk(16'(index_out), 16'(k == 2));
        end
        @(posedge ref_clk_in);
        ref_mark_in <= 1'b0;
    endtask : t_index
    task automatic t_down;
        steps(1'b0, 5);
        chk(position_out, 16'h27);
        chk(count, 16'h27);
        chk(16'({quad_phase_first_out, quad_phase_second_out}), 16'h1);
    endtask : t_down
    task automatic t_fault;
        for (int j = 0; j < 3; j++) begin
            @(posedge ref_clk_in);
            {supply_ok_in, light_ok_in, signal_ok_in} <= ~(3'h1 << j);
            wait_fault(1'b1);
            steps(1'b1, 2);
            chk(position_out, 16'h27);
            @(posedge ref_clk_in);
            {supply_ok_in, light_ok_in, signal_ok_in} <= 3'h7;
            wait_fault(1'b0);
        end
    endtask : t_fault
    initial begin
        repeat (8) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        @(negedge ref_clk_in);
        t_reset();
        t_period();
        t_index();
        t_down();
        t_fault();
        report_and_stop();
    end
endmodule : tb
bind quadrature_encoder_output quad_enc_monitor #(.POS_WIDTH(POS_WIDTH)) mon (.ref_clk_in, .srst_in, .step_in,
    .dir_up_in, .ref_mark_in, .supply_ok_in, .light_ok_in, .signal_ok_in, .quad_phase_first_out,
    .quad_phase_second_out, .index_out, .fault_out, .fault_n_out, .position_out);
`default_nettype wire

// file: design/quad_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module quad_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;

    if (WIDTH < 1) begin : g_bad_width
        $error("quad_pin_sync: WIDTH below 1");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk_in) begin
                if (srst_in) begin
                    meta_ff[i] <= INIT[i];
                    s2_ff[i] <= INIT[i];
                    s3_ff[i] <= INIT[i];
                    sync_out[i] <= INIT[i];
                end else begin
                    meta_ff[i] <= async_in[i];
                    s2_ff[i] <= meta_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    if (s2_ff[i] == s3_ff[i]) begin
                        sync_out[i] <= s3_ff[i];
                    end
                end
            end
        end
    endgenerate
endmodule : quad_pin_sync
`default_nettype wire

// file: design/quadrature_encoder_output.sv
`timescale 1ns/1ns
`default_nettype none
`include "quad_enc_consts.svh"

// Contract
// R1: The two channels form a quadrature pair with the second lagging the first by a quarter cycle.
// R2: The index is high once per reference mark for exactly one quarter cycle, gated with one channel state; here at each gated state during the mark.
// R3: The fault line is inactive in normal running and active on a fault, offered active high and active low.
// R4: Fault is raised on supply failure, light source loss, or track signals out of limits.
// R5: One track period equals 40 um of travel, subdivided by the interpolation into quarter steps.
// R6: The receiver counts up when the first channel leads and down when the second leads.
module quadrature_encoder_output #(
    parameter int INTERP_FACTOR = `QE_INTERP_FACTOR_DEF,
    parameter int POS_WIDTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic step_in,
    input wire logic dir_up_in,
    input wire logic ref_mark_in,
    input wire logic supply_ok_in,
    input wire logic light_ok_in,
    input wire logic signal_ok_in,
    output logic quad_phase_first_out,
    output logic quad_phase_second_out,
    output logic index_out,
    output logic fault_out,
    output logic fault_n_out,
    output logic [POS_WIDTH-1:0] position_out
);
    import quad_enc_pkg::*;

    localparam int STEPS_PER_PERIOD = `QE_QUARTERS_PER_CYCLE * INTERP_FACTOR;
    localparam int POS_WIDTH_MAX = 30;

    // Refuse settings that cannot hold a full track period of quarter steps
    if (INTERP_FACTOR < 1) begin : g_bad_factor
        $error("quadrature_encoder_output: INTERP_FACTOR below 1");
    end
    if (POS_WIDTH < 4 || POS_WIDTH > POS_WIDTH_MAX) begin : g_bad_width
        $error("quadrature_encoder_output: POS_WIDTH out of range");
    end else if (STEPS_PER_PERIOD >= (1 << POS_WIDTH)) begin : g_narrow_width
        $error("quadrature_encoder_output: POS_WIDTH too narrow for one period");
    end

    logic [2:0] pin_sync;
    logic supply_ok;
    logic light_ok;
    logic signal_ok;
    logic ref_mark_ff;
    logic ref_armed_ff;
    phase_type phase_ff;
    phase_type nxt_phase;
    logic [POS_WIDTH-1:0] pos_ff;
    logic [POS_WIDTH-1:0] nxt_pos;
    logic fault_ff;
    logic health_ok;
    logic step_ok;
    logic nxt_first;
    logic nxt_second;

    // Health pins come from the analog front end, so they are synchronised
    quad_pin_sync #(
        .WIDTH(3),
        .INIT(3'b000)
    ) u_health_sync (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .async_in({supply_ok_in, light_ok_in, signal_ok_in}),
        .sync_out(pin_sync)
    );
    assign supply_ok = pin_sync[2];
    assign light_ok = pin_sync[1];
    assign signal_ok = pin_sync[0];

    // R4: fault sources
    always_comb begin
        health_ok = 1'b1;
        if (!supply_ok) begin
            health_ok = 1'b0;
        end
        if (!light_ok) begin
            health_ok = 1'b0;
        end
        if (!signal_ok) begin
            health_ok = 1'b0;
        end
    end

    // R4: fault register
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            fault_ff <= `QE_FAULT_RESET;
        end else begin
            fault_ff <= !health_ok;
        end
    end

    // Steps are refused while the fault line shows, so a counter downstream
    // never sees an edge that the encoder itself does not stand behind
    assign step_ok = step_in && !fault_out;

    // R1: quarter cycle stepping
    always_comb begin
        nxt_phase = phase_ff;
        if (step_ok) begin
            case (phase_ff)
                PH_00: nxt_phase = dir_up_in ? PH_10 : PH_01;
                PH_10: nxt_phase = dir_up_in ? PH_11 : PH_00;
                PH_11: nxt_phase = dir_up_in ? PH_01 : PH_10;
                PH_01: nxt_phase = dir_up_in ? PH_00 : PH_11;
                default: nxt_phase = PH_00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            phase_ff <= PH_00;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // R1: channel levels per phase
    always_comb begin
        nxt_first = 1'b0;
        nxt_second = 1'b0;
        case (nxt_phase)
            PH_00: begin
                nxt_first = 1'b0;
                nxt_second = 1'b0;
            end
            PH_10: begin
                nxt_first = 1'b1;
                nxt_second = 1'b0;
            end
            PH_11: begin
                nxt_first = 1'b1;
                nxt_second = 1'b1;
            end
            PH_01: begin
                nxt_first = 1'b0;
                nxt_second = 1'b1;
            end
            default: begin
                nxt_first = 1'b0;
                nxt_second = 1'b0;
            end
        endcase
    end

    // R1: channels straight from flops; first leads when moving up
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            quad_phase_first_out <= `QE_PHASE_RESET;
            quad_phase_second_out <= `QE_PHASE_RESET;
        end else begin
            quad_phase_first_out <= nxt_first;
            quad_phase_second_out <= nxt_second;
        end
    end

    // R5: position in quarter steps; a track period is STEPS_PER_PERIOD of them
    always_comb begin
        nxt_pos = pos_ff;
        if (step_ok) begin
            if (dir_up_in) begin
                nxt_pos = pos_ff + 1'b1;
            end else begin
                nxt_pos = pos_ff - 1'b1;
            end
        end
    end

    // R5: count register
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            pos_ff <= '0;
        end else begin
            pos_ff <= nxt_pos;
        end
    end
    // Output copy takes the next value so it moves on the same edge as the channels
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            position_out <= '0;
        end else begin
            position_out <= nxt_pos;
        end
    end

    // R2: arm on reference mark, fire in every gating state while the mark stays high and fault_ff is clear
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ref_mark_ff <= 1'b0;
            ref_armed_ff <= 1'b0;
        end else begin
            ref_mark_ff <= ref_mark_in;
            if (ref_mark_in && !ref_mark_ff) begin
                ref_armed_ff <= 1'b1;
            end else if (!ref_mark_in) begin
                ref_armed_ff <= 1'b0;
            end
        end
    end

    // R2: index covers exactly the gated quarter cycle
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            index_out <= 1'b0;
        end else begin
            index_out <= ref_mark_in && (ref_armed_ff || ref_mark_ff) && !fault_ff &&
                         (nxt_phase == PH_11);
        end
    end

    // R3: both polarities of fault
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            fault_out <= `QE_FAULT_RESET;
            fault_n_out <= !`QE_FAULT_RESET;
        end else begin
            fault_out <= fault_ff;
            fault_n_out <= !fault_ff;
        end
    end
endmodule : quadrature_encoder_output
`default_nettype wire

// file: include/quad_enc_consts.svh
`ifndef QUAD_ENC_CONSTS_SVH
`define QUAD_ENC_CONSTS_SVH

// Scale grating period in micrometres: one electrical cycle of travel
`define QE_GRATING_PERIOD_UM 40
// Quarter cycles per electrical cycle
`define QE_QUARTERS_PER_CYCLE 4
// Default interpolation: edges per grating period equals 4 * factor
`define QE_INTERP_FACTOR_DEF 10
// Quadrature state on which the index is gated (first high, second high)
`define QE_INDEX_GATE_STATE 2'b11
// Fault and output reset values
`define QE_PHASE_RESET 1'b0
`define QE_FAULT_RESET 1'b1

`endif

// file: include/quad_enc_pkg.sv
package quad_enc_pkg;
    // Quadrature output phase state, in forward order
    typedef enum logic [1:0] {
        PH_00,
        PH_10,
        PH_11,
        PH_01
    } phase_type;

    typedef logic [1:0] quad_type;
endpackage : quad_enc_pkg
